// ---- hw/tcmp_consts.svh ----
`ifndef TCMP_CONSTS_SVH
`define TCMP_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TCMP_OFF_CTRL 8'h00
`define TCMP_OFF_FLAGS 8'h04
`define TCMP_OFF_IEN 8'h08
`define TCMP_OFF_CNT_LO 8'h0C
`define TCMP_OFF_CNT_HI 8'h10
`define TCMP_OFF_CMP_A 8'h14
`define TCMP_OFF_CMP_B 8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TCMP_CTRL_CLEAR_BIT 0
`define TCMP_CTRL_CAPTURE_BIT 6
`define TCMP_CTRL_WIDTH_BIT 7
`define TCMP_FLG_A_BIT 0
`define TCMP_FLG_B_BIT 1
`define TCMP_FLG_OV_BIT 2

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define TCMP_TOP8 8'hFF
`define TCMP_TOP16 16'hFFFF
`define TCMP_ZERO8 8'h00
`define TCMP_ZERO16 16'h0000
`define TCMP_ONE8 8'h01
`define TCMP_ONE16 16'h0001

`endif

// ---- hw/tcmp_pkg.sv ----
package tcmp_pkg;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		tcmp_normal8,
		tcmp_ctc8,
		tcmp_normal16,
		tcmp_cap8,
		tcmp_cap16
	} tcmp_mode_t;

	typedef struct packed {
		logic ovf;
		logic cmp_b;
		logic cmp_a;
	} tcmp_flags_t;

	typedef struct packed {
		logic width;
		logic capture;
		logic clear;
	} tcmp_ctrl_t;

endpackage

// ---- hw/tcmp_top.sv ----
// Notes on behaviour
// - Compare count with both compare registers, except in capture modes.
// - Match sets its flag on next tick.
// - Sixteen-bit mode sets flag A, never flag B.
// - Enabled flag requests interrupt; service clears it.
// - Writing one clears a flag; zero ignored.
// - Count write blocks matches for next tick.
// - Mode decoded from capture, width, clear bits.
// - Compare writes take effect immediately, except sixteen-bit B, held in temp until A write.
// - Eight-bit count wraps, sets overflow at zero.
// - Counter only sets overflow, never clears it.
// - Clear-on-match resets count at compare A.
// - Compare A below count: wrap first.
// - Clear-on-match sets flag A each period.
// - Clear-on-match overflow on roll to zero.
// - Sixteen-bit count wraps, sets overflow at zero.
// - Counter advances only on timer tick.
// - One shared temporary high byte register.
// - Sixteen-bit low byte write loads temp high too.
// - Low byte read copies high into temp.
// - Compare reads bypass temp, sixteen-bit capture reads don't.
// - Count write beats clear or increment.
// - Sixteen-bit capture uses compare B high.
`timescale 1ns/1ps
`include "tcmp_consts.svh"

module tcmp_top (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic timer_tick,
	input wire logic capture_event,
	input wire tcmp_pkg::tcmp_flags_t irq_ack,
	output tcmp_pkg::tcmp_flags_t irq_req
);
	import tcmp_pkg::*;

	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	logic [7:0] addr_r;
	logic wr_pend_r;
	logic rd_pend_r;
	logic hreadyout_r;
	logic hresp_r;
	logic [31:0] hrdata_r;
	logic take;
	logic [7:0] wbyte;
	logic [31:0] rd_val;

	assign take = hsel && htrans[1] && hready;
	assign wbyte = hwdata[7:0];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_r <= 8'h00;
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			hreadyout_r <= 1'b1;
		end else begin
			if (take) begin
				addr_r <= haddr[7:0];
			end
			wr_pend_r <= take && hwrite;
			rd_pend_r <= take && !hwrite;
			hreadyout_r <= !(take && !hwrite);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hrdata_r <= 32'h00000000;
			hresp_r <= 1'b0;
		end else if (rd_pend_r) begin
			hrdata_r <= rd_val;
		end
	end

	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;
	assign hrdata = hrdata_r;

	logic wr_ctrl, wr_flags, wr_ien, wr_cnt_lo, wr_cnt_hi, wr_cmp_a, wr_cmp_b;
	logic rd_cnt_lo, rd_cmp_a;

	assign wr_ctrl = wr_pend_r && addr_r == `TCMP_OFF_CTRL;
	assign wr_flags = wr_pend_r && addr_r == `TCMP_OFF_FLAGS;
	assign wr_ien = wr_pend_r && addr_r == `TCMP_OFF_IEN;
	assign wr_cnt_lo = wr_pend_r && addr_r == `TCMP_OFF_CNT_LO;
	assign wr_cnt_hi = wr_pend_r && addr_r == `TCMP_OFF_CNT_HI;
	assign wr_cmp_a = wr_pend_r && addr_r == `TCMP_OFF_CMP_A;
	assign wr_cmp_b = wr_pend_r && addr_r == `TCMP_OFF_CMP_B;
	assign rd_cnt_lo = rd_pend_r && addr_r == `TCMP_OFF_CNT_LO;
	assign rd_cmp_a = rd_pend_r && addr_r == `TCMP_OFF_CMP_A;

	// ------------------------------------------------------------------
	// Control and mode
	// ------------------------------------------------------------------
	tcmp_ctrl_t ctrl_r;
	tcmp_mode_t mode;
	logic wide;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= '0;
		end else if (wr_ctrl) begin
			ctrl_r.width <= wbyte[`TCMP_CTRL_WIDTH_BIT];
			ctrl_r.capture <= wbyte[`TCMP_CTRL_CAPTURE_BIT];
			ctrl_r.clear <= wbyte[`TCMP_CTRL_CLEAR_BIT];
		end
	end

	always_comb begin
		case ({ctrl_r.capture, ctrl_r.width, ctrl_r.clear})
			3'b000: mode = tcmp_normal8;
			3'b001: mode = tcmp_ctc8;
			3'b010, 3'b011: mode = tcmp_normal16;
			3'b100, 3'b101: mode = tcmp_cap8;
			default: mode = tcmp_cap16;
		endcase
	end

	assign wide = ctrl_r.width;

	// ------------------------------------------------------------------
	// Compare and count
	// ------------------------------------------------------------------
	logic [15:0] count_r;
	logic [7:0] cmp_a_r;
	logic [7:0] cmp_b_r;
	logic [7:0] temp_r;
	logic block_r;
	logic [7:0] cnt_lo;
	logic cnt_wr;
	logic match_a, match_b, ctc_clear, wrap;

	assign cnt_lo = count_r[7:0];
	assign cnt_wr = wr_cnt_lo || wr_cnt_hi;
	assign wrap = wide ? (count_r == `TCMP_TOP16) : (cnt_lo == `TCMP_TOP8);
	assign ctc_clear = (mode == tcmp_ctc8) && (cnt_lo == cmp_a_r);

	always_comb begin
		case (mode)
			tcmp_normal8, tcmp_ctc8: begin
				match_a = cnt_lo == cmp_a_r;
				match_b = cnt_lo == cmp_b_r;
			end
			tcmp_normal16: begin
				match_a = count_r == {cmp_b_r, cmp_a_r};
				match_b = 1'b0;
			end
			tcmp_cap8: begin
				match_a = 1'b0;
				match_b = cnt_lo == cmp_b_r;
			end
			default: begin
				match_a = 1'b0;
				match_b = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_r <= `TCMP_ZERO16;
		end else if (wr_cnt_lo) begin
			if (wide) begin
				count_r <= {temp_r, wbyte};
			end else begin
				count_r[7:0] <= wbyte;
			end
		end else if (timer_tick) begin
			if (ctc_clear) begin
				count_r[7:0] <= `TCMP_ZERO8;
			end else if (wide) begin
				count_r <= count_r + `TCMP_ONE16;
			end else begin
				count_r[7:0] <= cnt_lo + `TCMP_ONE8;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			block_r <= 1'b0;
		end else if (cnt_wr) begin
			block_r <= 1'b1;
		end else if (timer_tick) begin
			block_r <= 1'b0;
		end
	end

	// Compare values change at once, except a sixteen-bit compare B write, which waits in temp for the compare A write.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp_a_r <= `TCMP_ZERO8;
			cmp_b_r <= `TCMP_ZERO8;
		end else begin
			if (wr_cmp_a) begin
				cmp_a_r <= wbyte;
				if (wide) begin
					cmp_b_r <= temp_r;
				end
			end else if (wr_cmp_b && !wide) begin
				cmp_b_r <= wbyte;
			end else if (capture_event && ctrl_r.capture) begin
				cmp_a_r <= cnt_lo;
				if (wide) begin
					cmp_b_r <= count_r[15:8];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			temp_r <= `TCMP_ZERO8;
		end else if (wr_cnt_hi || (wr_cmp_b && wide)) begin
			temp_r <= wbyte;
		end else if (rd_cnt_lo) begin
			temp_r <= count_r[15:8];
		end else if (rd_cmp_a && mode == tcmp_cap16) begin
			temp_r <= cmp_b_r;
		end
	end

	// ------------------------------------------------------------------
	// Flags and interrupt requests
	// ------------------------------------------------------------------
	logic [2:0] flg_r;
	logic [2:0] ien_r;
	logic [2:0] set_v;
	logic [2:0] clr_v;
	logic [2:0] irq_r;

	assign set_v[`TCMP_FLG_A_BIT] = timer_tick && match_a && !block_r;
	assign set_v[`TCMP_FLG_B_BIT] = timer_tick && match_b && !block_r;
	assign set_v[`TCMP_FLG_OV_BIT] = timer_tick && wrap && !wr_cnt_lo;
	assign clr_v = irq_ack | ({3{wr_flags}} & wbyte[2:0]);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_flag
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					flg_r[gi] <= 1'b0;
				end else if (set_v[gi]) begin
					flg_r[gi] <= 1'b1;
				end else if (clr_v[gi]) begin
					flg_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ien_r <= 3'h0;
			irq_r <= 3'h0;
		end else begin
			if (wr_ien) begin
				ien_r <= wbyte[2:0];
			end
			irq_r <= flg_r & ien_r & ~irq_ack;
		end
	end

	assign irq_req = tcmp_flags_t'(irq_r);

	always_comb begin
		rd_val = 32'h00000000;
		case (addr_r)
			`TCMP_OFF_CTRL: begin
				rd_val[`TCMP_CTRL_WIDTH_BIT] = ctrl_r.width;
				rd_val[`TCMP_CTRL_CAPTURE_BIT] = ctrl_r.capture;
				rd_val[`TCMP_CTRL_CLEAR_BIT] = ctrl_r.clear;
			end
			`TCMP_OFF_FLAGS: rd_val[2:0] = flg_r;
			`TCMP_OFF_IEN: rd_val[2:0] = ien_r;
			`TCMP_OFF_CNT_LO: rd_val[7:0] = cnt_lo;
			`TCMP_OFF_CNT_HI: rd_val[7:0] = wide ? temp_r : count_r[15:8];
			`TCMP_OFF_CMP_A: rd_val[7:0] = cmp_a_r;
			`TCMP_OFF_CMP_B: rd_val[7:0] = (mode == tcmp_cap16) ? temp_r : cmp_b_r;
			default: rd_val = 32'h00000000;
		endcase
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_flag_a_cause;
		@(posedge clk) disable iff (!arst_n)
		$rose(flg_r[`TCMP_FLG_A_BIT]) |-> $past(timer_tick && match_a && !block_r);
	endproperty
	a_flag_a_cause: assert property (p_flag_a_cause) else $error("flag A set without match");
	property p_block;
		@(posedge clk) disable iff (!arst_n)
		(timer_tick && block_r && !cnt_wr && flg_r[1:0] == 2'b00) |=> flg_r[1:0] == 2'b00;
	endproperty
	a_block: assert property (p_block) else $error("match not blocked after count write");
	property p_ov8;
		@(posedge clk) disable iff (!arst_n)
		(!wide && timer_tick && !cnt_wr && cnt_lo == `TCMP_TOP8 && !ctc_clear)
			|=> (count_r[7:0] == `TCMP_ZERO8) && flg_r[`TCMP_FLG_OV_BIT];
	endproperty
	a_ov8: assert property (p_ov8) else $error("8-bit wrap wrong");
	property p_ov16;
		@(posedge clk) disable iff (!arst_n)
		(wide && timer_tick && !cnt_wr && count_r == `TCMP_TOP16)
			|=> (count_r == `TCMP_ZERO16) && flg_r[`TCMP_FLG_OV_BIT];
	endproperty
	a_ov16: assert property (p_ov16) else $error("16-bit wrap wrong");
	property p_ctc;
		@(posedge clk) disable iff (!arst_n)
		(ctc_clear && timer_tick && !cnt_wr && !block_r)
			|=> count_r[7:0] == `TCMP_ZERO8 && flg_r[`TCMP_FLG_A_BIT];
	endproperty
	a_ctc: assert property (p_ctc) else $error("clear on match failed");
	property p_ctc_miss;
		@(posedge clk) disable iff (!arst_n)
		(mode == tcmp_ctc8 && timer_tick && !cnt_wr && cnt_lo > cmp_a_r && !wr_cmp_a
			&& cnt_lo != `TCMP_TOP8) |=> count_r[7:0] == 8'($past(cnt_lo) + `TCMP_ONE8);
	endproperty
	a_ctc_miss: assert property (p_ctc_miss) else $error("counter did not run past");
	property p_ov_only_set;
		@(posedge clk) disable iff (!arst_n)
		$fell(flg_r[`TCMP_FLG_OV_BIT]) |-> $past(clr_v[`TCMP_FLG_OV_BIT]);
	endproperty
	a_ov_only_set: assert property (p_ov_only_set) else $error("overflow cleared by hw");
	property p_w1c;
		@(posedge clk) disable iff (!arst_n)
		(wr_flags && wbyte[`TCMP_FLG_A_BIT] && !set_v[`TCMP_FLG_A_BIT])
			|=> !flg_r[`TCMP_FLG_A_BIT];
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear");
	property p_cnt_wr;
		@(posedge clk) disable iff (!arst_n)
		(wr_cnt_lo && wide) |=> count_r == {$past(temp_r), $past(hwdata[7:0])};
	endproperty
	a_cnt_wr: assert property (p_cnt_wr) else $error("16-bit count write lost");
	property p_temp_rd;
		@(posedge clk) disable iff (!arst_n)
		rd_cnt_lo |=> temp_r == $past(count_r[15:8]);
	endproperty
	a_temp_rd: assert property (p_temp_rd) else $error("temp not loaded on read");
	property p_b_16;
		@(posedge clk) disable iff (!arst_n)
		$rose(flg_r[`TCMP_FLG_B_BIT]) |-> $past(!wide);
	endproperty
	a_b_16: assert property (p_b_16) else $error("flag B set in 16-bit mode");
	property p_hold;
		@(posedge clk) disable iff (!arst_n)
		(!timer_tick && !cnt_wr) |=> $stable(count_r);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved without tick");

endmodule

// ---- testbench/tcmp_cpu_model.sv ----
`timescale 1ns/1ps

module tcmp_cpu_model (
	input wire logic clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [31:0] hwdata
);
	// ------------------------------------------------------------------
	// Single word transfers as seen from the processor side
	// ------------------------------------------------------------------
	initial begin
		hsel = 1'h0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hwdata = 32'h00000000;
	end

	// Called right after a rising edge; returns at the edge that ends the data phase.
	// Write data is inverted during the address phase so stale data never looks valid.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		hwdata <= ~hwdata;
		do @(posedge clk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		do @(posedge clk); while (hready !== 1'h1);
		rd = hrdata[7:0];
	endtask
endmodule

// ---- testbench/tcmp_top_bench.sv ----
`timescale 1ns/1ps
`include "tcmp_consts.svh"

module tcmp_top_bench;
	import tcmp_pkg::*;
	logic clk = 1'h0;
	logic arst_n;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic timer_tick;
	logic capture_event;
	tcmp_flags_t irq_ack;
	tcmp_flags_t irq_req;
	int errors = 0;
	int check_count = 0;

	always #5 clk = ~clk;

	tcmp_top i_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .timer_tick(timer_tick), .capture_event(capture_event),
		.irq_ack(irq_ack), .irq_req(irq_req));

	tcmp_cpu_model i_cpu (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		i_cpu.xfer(1'h1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] x;
		i_cpu.xfer(1'h0, a, 8'h00, x);
		check(x, exp);
	endtask

	task automatic tick(input int n);
		timer_tick <= 1'h1;
		repeat (n) @(posedge clk);
		timer_tick <= 1'h0;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		check({7'h00, hresp}, 8'h00);
		for (int a = 0; a <= 28; a += 4) begin
			rd(a[7:0], 8'h00);
		end
	endtask

	task automatic t_normal8;
		wr(`TCMP_OFF_CTRL, 8'h00);
		wr(`TCMP_OFF_CMP_A, 8'h05);
		wr(`TCMP_OFF_CMP_B, 8'h07);
		wr(`TCMP_OFF_CNT_LO, 8'h03);
		tick(2);
		rd(`TCMP_OFF_FLAGS, 8'h00);
		tick(1);
		rd(`TCMP_OFF_FLAGS, 8'h01);
		tick(2);
		rd(`TCMP_OFF_FLAGS, 8'h03);
		wr(`TCMP_OFF_FLAGS, 8'h01);
		rd(`TCMP_OFF_FLAGS, 8'h02);
		wr(`TCMP_OFF_FLAGS, 8'h02);
		wr(`TCMP_OFF_CNT_LO, 8'hFE);
		tick(1);
		rd(`TCMP_OFF_FLAGS, 8'h00);
		tick(1);
		rd(`TCMP_OFF_FLAGS, 8'h04);
		tick(3);
		rd(`TCMP_OFF_FLAGS, 8'h04);
		rd(`TCMP_OFF_CNT_LO, 8'h03);
	endtask

	task automatic t_block;
		wr(`TCMP_OFF_FLAGS, 8'h07);
		wr(`TCMP_OFF_CNT_LO, 8'h05);
		tick(1);
		rd(`TCMP_OFF_FLAGS, 8'h00);
		timer_tick <= 1'h1;
		wr(`TCMP_OFF_CNT_LO, 8'h40);
		timer_tick <= 1'h0;
		rd(`TCMP_OFF_CNT_LO, 8'h40);
	endtask

	task automatic t_ctc;
		wr(`TCMP_OFF_CTRL, 8'h01);
		wr(`TCMP_OFF_CMP_A, 8'h03);
		wr(`TCMP_OFF_CNT_LO, 8'h00);
		wr(`TCMP_OFF_FLAGS, 8'h07);
		tick(4);
		rd(`TCMP_OFF_CNT_LO, 8'h00);
		rd(`TCMP_OFF_FLAGS, 8'h01);
		wr(`TCMP_OFF_CNT_LO, 8'h10);
		wr(`TCMP_OFF_FLAGS, 8'h07);
		tick(240);
		rd(`TCMP_OFF_CNT_LO, 8'h00);
		rd(`TCMP_OFF_FLAGS, 8'h04);
	endtask

	task automatic t_wide;
		wr(`TCMP_OFF_CTRL, 8'h80);
		wr(`TCMP_OFF_CNT_HI, 8'hFF);
		wr(`TCMP_OFF_CNT_LO, 8'hFE);
		wr(`TCMP_OFF_CNT_HI, 8'h11);
		rd(`TCMP_OFF_CNT_LO, 8'hFE);
		rd(`TCMP_OFF_CNT_HI, 8'hFF);
		wr(`TCMP_OFF_FLAGS, 8'h07);
		tick(2);
		rd(`TCMP_OFF_FLAGS, 8'h04);
		rd(`TCMP_OFF_CNT_LO, 8'h00);
		rd(`TCMP_OFF_CNT_HI, 8'h00);
		wr(`TCMP_OFF_CMP_B, 8'h01);
		wr(`TCMP_OFF_CMP_A, 8'h03);
		wr(`TCMP_OFF_CNT_HI, 8'h01);
		wr(`TCMP_OFF_CNT_LO, 8'h00);
		wr(`TCMP_OFF_FLAGS, 8'h07);
		tick(4);
		rd(`TCMP_OFF_FLAGS, 8'h01);
		wr(`TCMP_OFF_CNT_HI, 8'h77);
		rd(`TCMP_OFF_CMP_A, 8'h03);
		rd(`TCMP_OFF_CMP_B, 8'h01);
	endtask

	task automatic t_irq;
		wr(`TCMP_OFF_IEN, 8'h01);
		repeat (2) @(posedge clk);
		check({5'h00, irq_req}, 8'h01);
		irq_ack <= 3'h1;
		@(posedge clk);
		irq_ack <= 3'h0;
		rd(`TCMP_OFF_FLAGS, 8'h00);
		check({5'h00, irq_req}, 8'h00);
	endtask

	task automatic t_capture;
		wr(`TCMP_OFF_CTRL, 8'h40);
		wr(`TCMP_OFF_CNT_LO, 8'h21);
		capture_event <= 1'h1;
		@(posedge clk);
		capture_event <= 1'h0;
		rd(`TCMP_OFF_CMP_A, 8'h21);
		rd(`TCMP_OFF_CMP_B, 8'h01);
		wr(`TCMP_OFF_CTRL, 8'hC0);
		wr(`TCMP_OFF_CNT_HI, 8'h12);
		wr(`TCMP_OFF_CNT_LO, 8'h34);
		capture_event <= 1'h1;
		@(posedge clk);
		capture_event <= 1'h0;
		wr(`TCMP_OFF_CNT_HI, 8'h55);
		rd(`TCMP_OFF_CMP_A, 8'h34);
		rd(`TCMP_OFF_CMP_B, 8'h12);
	endtask

	// ------------------------------------------------------------------
	// Sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		arst_n = 1'h0;
		timer_tick = 1'h0;
		capture_event = 1'h0;
		irq_ack = 3'h0;
		repeat (20) @(posedge clk);
		arst_n <= 1'h1;
		@(posedge clk);
		t_reset;
		t_normal8;
		t_block;
		t_ctc;
		t_wide;
		t_irq;
		t_capture;
		print_verdict;
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		print_verdict;
	end
endmodule
